// ==== vig_device.sv ====
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module vig_device (
    input wire logic clock,
    input wire logic rst_n,
    vig_if.device bus
);
    typedef struct packed {
        logic [vig_pkg::SY_W-1:0] s1;
        logic [vig_pkg::SY_W-1:0] s2;
        logic [vig_pkg::SY_W-1:0] s3;
        logic [vig_pkg::SY_W-1:0] f;
        logic [7:1] vec;
        logic [7:1] req;
        logic [7:1] irq_n;
        vig_pkg::vig_local_e lst;
        vig_pkg::vig_sys_e sst;
        logic [6:0] ld_out;
        logic ld_oe_n;
        logic ack_oe_n;
        logic iackout_n;
        logic dtack_n;
        logic bufen_n;
        logic [6:0] vout;
    } vig_dev_s;

    vig_dev_s q;
    vig_dev_s next_q;

    // ------------------------------------------------------------
    // Synchronised inputs.
    // ------------------------------------------------------------
    logic [vig_pkg::SY_W-1:0] raw;
    assign raw = {bus.ds0_n, bus.iackin_n, bus.iack_n, bus.level_addr,
                  bus.local_read_write_n, bus.register_select,
                  bus.qualified_chip_select_n, bus.local_data_bus};

    logic [6:0] ld;
    logic cs_n;
    logic rs;
    logic rw_n;
    logic [2:0] lvl;
    logic start;
    logic quit;
    assign ld = q.f[vig_pkg::SY_LD +: 7];
    assign cs_n = q.f[vig_pkg::SY_CS];
    assign rs = q.f[vig_pkg::SY_RS];
    assign rw_n = q.f[vig_pkg::SY_RW];
    assign lvl = q.f[vig_pkg::SY_A +: 3];
    assign start = !q.f[vig_pkg::SY_IACK] && !q.f[vig_pkg::SY_IACKIN]
        && !q.f[vig_pkg::SY_DS];
    assign quit = q.f[vig_pkg::SY_DS] || q.f[vig_pkg::SY_IACK];

    // ------------------------------------------------------------
    // Local access decodes.
    // ------------------------------------------------------------
    // Local data bit k carries register bit k+1.
    logic clear_all;
    logic [6:0] rd_value;
    assign clear_all = ld[vig_pkg::VEC_CLEAR_BIT - 1];
    assign rd_value = (rs == vig_pkg::RS_VECTOR) ? q.vec : q.req;

    // ------------------------------------------------------------
    // Acknowledge decodes.
    // ------------------------------------------------------------
    logic [7:0] req_ext;
    logic enabled;
    logic hit;
    logic [6:0] answer;
    assign req_ext = {q.req, 1'b0};
    assign enabled = q.vec[vig_pkg::VEC_ENABLE_BIT];
    assign hit = lvl != vig_pkg::LEVEL_NONE && enabled && req_ext[lvl];
    assign answer = {q.vec[7:vig_pkg::VEC_ID_LO], lvl[2:1]};

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb begin
        logic [7:1] set_bits;
        logic [7:1] clr_bits;
        set_bits = '0;
        clr_bits = '0;
        next_q = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.f = (q.s2 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));

        // --------------------------------------------------------
        // Local register side.
        // --------------------------------------------------------
        case (q.lst)
            vig_pkg::L_IDLE: begin
                if (!cs_n) begin
                    if (!rw_n) begin
                        if (rs == vig_pkg::RS_VECTOR) begin
                            next_q.vec = ld;
                            next_q.vec[vig_pkg::VEC_CLEAR_BIT] = 1'b0;
                            if (clear_all) begin
                                clr_bits = '1;
                            end
                        end else begin
                            set_bits = ld;
                        end
                    end else begin
                        next_q.ld_oe_n = 1'b0;
                        next_q.ld_out = rd_value;
                    end
                    next_q.ack_oe_n = 1'b0;
                    next_q.lst = vig_pkg::L_ACK;
                end
            end
            vig_pkg::L_ACK: begin
                if (cs_n) begin
                    next_q.ack_oe_n = 1'b1;
                    next_q.ld_oe_n = 1'b1;
                    next_q.lst = vig_pkg::L_IDLE;
                end
            end
            default: begin
                next_q.lst = vig_pkg::L_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // System acknowledge side, in parallel with the local side.
        // --------------------------------------------------------
        case (q.sst)
            vig_pkg::S_IDLE: begin
                if (start) begin
                    if (hit) begin
                        clr_bits[lvl] = 1'b1;
                        next_q.bufen_n = 1'b0;
                        next_q.dtack_n = 1'b0;
                        next_q.vout = answer;
                        next_q.sst = vig_pkg::S_RESP;
                    end else begin
                        next_q.iackout_n = 1'b0;
                        next_q.sst = vig_pkg::S_PASS;
                    end
                end
            end
            vig_pkg::S_RESP: begin
                if (quit) begin
                    next_q.bufen_n = 1'b1;
                    next_q.dtack_n = 1'b1;
                    next_q.vout = '0;
                    next_q.sst = vig_pkg::S_IDLE;
                end
            end
            vig_pkg::S_PASS: begin
                next_q.iackout_n = q.f[vig_pkg::SY_IACKIN];
                if (quit) begin
                    next_q.iackout_n = 1'b1;
                    next_q.sst = vig_pkg::S_IDLE;
                end
            end
            default: begin
                next_q.sst = vig_pkg::S_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // Request register and request outputs.
        // --------------------------------------------------------
        // A new request beats a clear in the same cycle.
        next_q.req = (q.req & ~clr_bits) | set_bits;
        next_q.irq_n = ~(next_q.req &
            {vig_pkg::LEVELS{next_q.vec[vig_pkg::VEC_ENABLE_BIT]}});
    end

    // ------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q.s1 <= vig_pkg::SY_IDLE;
            q.s2 <= vig_pkg::SY_IDLE;
            q.s3 <= vig_pkg::SY_IDLE;
            q.f <= vig_pkg::SY_IDLE;
            q.vec <= '0;
            q.req <= '0;
            q.irq_n <= '1;
            q.lst <= vig_pkg::L_IDLE;
            q.sst <= vig_pkg::S_IDLE;
            q.ld_out <= '0;
            q.ld_oe_n <= 1'b1;
            q.ack_oe_n <= 1'b1;
            q.iackout_n <= 1'b1;
            q.dtack_n <= 1'b1;
            q.bufen_n <= 1'b1;
            q.vout <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign bus.dev_data_out = q.ld_out;
    assign bus.dev_data_oe_n = q.ld_oe_n;
    assign bus.ack_out = 1'b0;
    assign bus.ack_oe_n = q.ack_oe_n;
    assign bus.iackout_n = q.iackout_n;
    assign bus.dtack_n = q.dtack_n;
    assign bus.vector_buffer_enable_n = q.bufen_n;
    assign bus.vector_data_out = q.vout;
    assign bus.irq_n = q.irq_n;
endmodule : vig_device
`default_nettype wire

// ==== vig_pkg.sv ====
// Contract
// - Handler puts acknowledged level on A3..A1, A1 LSB.
// - Local side qualifies chip select with its strobe.
// - Select low is vector register, high is request.
// - Vector bit 1 enables all seven levels.
// - Vector bit 2 clears all requests, reads zero.
// - Vector out is vector bits 7-3, A3, A2.
// - Outside logic supplies the status byte LSB.
// - Writing ones raises those request levels together.
// - Writing zero leaves a level unchanged.
// - A pending level is not requested again.
// - Software checks no pending before changing vector.
// - Local access ends with open-collector acknowledge low.
// - Acknowledge starts only with IACK, IACKIN, DS0 low.
// - Pending level: clear it, drive vector, DTACK.
// - Not pending: pass daisy-chain input to IACKOUT.
// - Local and system sides run independently, no stalls.
// - Reset releases requests and chain, clears registers.
// - Both registers read back; request shows pending.
package vig_pkg;
    localparam int LEVELS = 7;
    localparam logic [6:0] BUS_PULLUP = 7'h7F;
    localparam logic RS_VECTOR = 1'b0;
    localparam logic RS_REQUEST = 1'b1;
    localparam int VEC_ENABLE_BIT = 1;
    localparam int VEC_CLEAR_BIT = 2;
    localparam int VEC_ID_LO = 3;
    localparam logic [2:0] LEVEL_NONE = 3'h0;
    // Device synchroniser lanes.
    localparam int SY_W = 16;
    localparam int SY_LD = 0;
    localparam int SY_CS = 7;
    localparam int SY_RS = 8;
    localparam int SY_RW = 9;
    localparam int SY_A = 10;
    localparam int SY_IACK = 13;
    localparam int SY_IACKIN = 14;
    localparam int SY_DS = 15;
    localparam logic [15:0] SY_IDLE = 16'hE080;
    // Host synchroniser lanes.
    localparam int HS_W = 24;
    localparam int HS_ACK = 0;
    localparam int HS_DTACK = 1;
    localparam int HS_IACKOUT = 2;
    localparam int HS_LD = 3;
    localparam int HS_VEC = 10;
    localparam int HS_IRQ = 17;
    localparam logic [23:0] HS_IDLE = 24'hFE03FF;
    // Host command port.
    localparam logic [1:0] HA_LOCAL_CMD = 2'h0;
    localparam logic [1:0] HA_LOCAL_DATA = 2'h1;
    localparam logic [1:0] HA_IACK_CMD = 2'h2;
    localparam logic [1:0] HA_IACK_RESULT = 2'h3;
    localparam int HF_RS = 8;
    localparam int HF_READ = 9;
    localparam int HF_BUSY = 0;
    localparam int HF_GOT = 1;
    localparam int HF_PASSED = 2;
    localparam int HF_VEC = 8;
    typedef enum logic [0:0] {
        L_IDLE = 1'b0,
        L_ACK = 1'b1
    } vig_local_e;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RESP = 2'b01,
        S_PASS = 2'b10
    } vig_sys_e;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOC = 3'b001,
        H_LOCEND = 3'b010,
        H_IAK = 3'b011,
        H_IAKEND = 3'b100
    } vig_host_e;
endpackage : vig_pkg

// ==== vig_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface vig_if;
    logic [2:0] level_addr;
    logic qualified_chip_select_n;
    logic register_select;
    logic local_read_write_n;
    logic [6:0] host_data_out;
    logic host_data_oe_n;
    logic [6:0] dev_data_out;
    logic dev_data_oe_n;
    logic [6:0] local_data_bus;
    logic ack_out;
    logic ack_oe_n;
    logic local_transfer_ack_n;
    logic iack_n;
    logic iackin_n;
    logic ds0_n;
    logic iackout_n;
    logic dtack_n;
    logic vector_buffer_enable_n;
    logic [6:0] vector_data_out;
    logic [7:1] irq_n;

    assign local_data_bus = !host_data_oe_n ? host_data_out :
        (!dev_data_oe_n ? dev_data_out : vig_pkg::BUS_PULLUP);
    assign local_transfer_ack_n = ack_oe_n ? 1'b1 : ack_out;

    modport device(
        input level_addr, qualified_chip_select_n, register_select,
        input local_read_write_n, local_data_bus, iack_n, iackin_n, ds0_n,
        output dev_data_out, dev_data_oe_n, ack_out, ack_oe_n,
        output iackout_n, dtack_n, vector_buffer_enable_n,
        output vector_data_out, irq_n
    );
    modport host(
        output level_addr, qualified_chip_select_n, register_select,
        output local_read_write_n, host_data_out, host_data_oe_n,
        output iack_n, iackin_n, ds0_n,
        input local_data_bus, local_transfer_ack_n, iackout_n, dtack_n,
        input vector_buffer_enable_n, vector_data_out, irq_n
    );
endinterface : vig_if
`default_nettype wire

// ==== vig_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module vig_host (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    vig_if.host bus
);
    typedef struct packed {
        logic [vig_pkg::HS_W-1:0] s1;
        logic [vig_pkg::HS_W-1:0] s2;
        logic [vig_pkg::HS_W-1:0] s3;
        logic [vig_pkg::HS_W-1:0] f;
        vig_pkg::vig_host_e st;
        logic cs_n;
        logic rs;
        logic rw_n;
        logic [6:0] dout;
        logic doe_n;
        logic [2:0] lvl;
        logic iack_n;
        logic ds_n;
        logic [6:0] ldata;
        logic got;
        logic passed;
        logic [6:0] vec;
        logic [15:0] rdata;
    } vig_host_s;

    vig_host_s q;
    vig_host_s next_q;
    logic [vig_pkg::HS_W-1:0] raw;
    logic busy;

    assign raw = {bus.irq_n, bus.vector_data_out, bus.local_data_bus,
                  bus.iackout_n, bus.dtack_n, bus.local_transfer_ack_n};
    assign busy = q.st != vig_pkg::H_IDLE;

    always_comb begin
        next_q = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.f = (q.s2 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
        next_q.rdata = '0;
        if (rd) begin
            case (addr)
                vig_pkg::HA_LOCAL_CMD: begin
                    next_q.rdata = {9'h000,
                                    ~q.f[vig_pkg::HS_IRQ +: 7]};
                end
                vig_pkg::HA_LOCAL_DATA: begin
                    next_q.rdata = {9'h000, q.ldata};
                end
                vig_pkg::HA_IACK_RESULT: begin
                    next_q.rdata = {1'b0, q.vec, 5'h00, q.passed, q.got,
                                    busy};
                end
                default: begin
                    next_q.rdata = {15'h0000, busy};
                end
            endcase
        end
        case (q.st)
            vig_pkg::H_IDLE: begin
                if (wr && addr == vig_pkg::HA_LOCAL_CMD) begin
                    next_q.rs = wdata[vig_pkg::HF_RS];
                    next_q.rw_n = wdata[vig_pkg::HF_READ];
                    next_q.dout = wdata[6:0];
                    next_q.doe_n = wdata[vig_pkg::HF_READ];
                    next_q.cs_n = 1'b0;
                    next_q.st = vig_pkg::H_LOC;
                end else if (wr && addr == vig_pkg::HA_IACK_CMD) begin
                    next_q.lvl = wdata[2:0];
                    next_q.iack_n = 1'b0;
                    next_q.ds_n = 1'b0;
                    next_q.got = 1'b0;
                    next_q.passed = 1'b0;
                    next_q.st = vig_pkg::H_IAK;
                end
            end
            vig_pkg::H_LOC: begin
                if (!q.f[vig_pkg::HS_ACK]) begin
                    if (q.rw_n) begin
                        next_q.ldata = q.f[vig_pkg::HS_LD +: 7];
                    end
                    next_q.cs_n = 1'b1;
                    next_q.doe_n = 1'b1;
                    next_q.st = vig_pkg::H_LOCEND;
                end
            end
            vig_pkg::H_IAK: begin
                if (!q.f[vig_pkg::HS_DTACK]) begin
                    next_q.vec = q.f[vig_pkg::HS_VEC +: 7];
                    next_q.got = 1'b1;
                    next_q.iack_n = 1'b1;
                    next_q.ds_n = 1'b1;
                    next_q.st = vig_pkg::H_IAKEND;
                end else if (!q.f[vig_pkg::HS_IACKOUT]) begin
                    next_q.passed = 1'b1;
                    next_q.iack_n = 1'b1;
                    next_q.ds_n = 1'b1;
                    next_q.st = vig_pkg::H_IAKEND;
                end
            end
            vig_pkg::H_LOCEND: begin
                if (q.f[vig_pkg::HS_ACK]) begin
                    next_q.st = vig_pkg::H_IDLE;
                end
            end
            vig_pkg::H_IAKEND: begin
                if (q.f[vig_pkg::HS_DTACK] && q.f[vig_pkg::HS_IACKOUT]) begin
                    next_q.st = vig_pkg::H_IDLE;
                end
            end
            default: begin
                next_q.st = vig_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q.s1 <= vig_pkg::HS_IDLE;
            q.s2 <= vig_pkg::HS_IDLE;
            q.s3 <= vig_pkg::HS_IDLE;
            q.f <= vig_pkg::HS_IDLE;
            q.st <= vig_pkg::H_IDLE;
            q.cs_n <= 1'b1;
            q.rs <= 1'b0;
            q.rw_n <= 1'b1;
            q.dout <= '0;
            q.doe_n <= 1'b1;
            q.lvl <= '0;
            q.iack_n <= 1'b1;
            q.ds_n <= 1'b1;
            q.ldata <= '0;
            q.got <= 1'b0;
            q.passed <= 1'b0;
            q.vec <= '0;
            q.rdata <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rdata = q.rdata;
    assign bus.level_addr = q.lvl;
    assign bus.qualified_chip_select_n = q.cs_n;
    assign bus.register_select = q.rs;
    assign bus.local_read_write_n = q.rw_n;
    assign bus.host_data_out = q.dout;
    assign bus.host_data_oe_n = q.doe_n;
    assign bus.iack_n = q.iack_n;
    assign bus.iackin_n = q.iack_n;
    assign bus.ds0_n = q.ds_n;
endmodule : vig_host
`default_nettype wire

// ==== vig_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module vig_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] level_addr,
    input wire logic qualified_chip_select_n,
    input wire logic local_transfer_ack_n,
    input wire logic dev_data_oe_n,
    input wire logic iack_n,
    input wire logic iackin_n,
    input wire logic ds0_n,
    input wire logic iackout_n,
    input wire logic dtack_n,
    input wire logic vector_buffer_enable_n,
    input wire logic [6:0] vector_data_out,
    input wire logic [7:1] irq_n
);
    // ----------
    // Helpers.
    // ----------
    logic iack_on;
    assign iack_on = !iack_n && !iackin_n && !ds0_n;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_answer;
        !dtack_n && !vector_buffer_enable_n && iackout_n;
    endsequence
    sequence s_sys_idle;
        dtack_n && iackout_n && vector_buffer_enable_n;
    endsequence
    sequence s_loc_idle;
        local_transfer_ack_n && dev_data_oe_n;
    endsequence
    // ----------
    // Assertions.
    // ----------
    a_reset_idle: assert property ($rose(rst_n) |->
        irq_n == 7'h7F && iackout_n && dtack_n)
        else $error("Outputs not idle after reset.");
    a_ack_follows_cs: assert property (
        $fell(qualified_chip_select_n) |-> ##[1:8] !local_transfer_ack_n)
        else $error("Local acknowledge missing.");
    a_ack_in_access: assert property (
        $fell(local_transfer_ack_n) |-> !qualified_chip_select_n)
        else $error("Local acknowledge without select.");
    a_ack_release: assert property (
        $rose(qualified_chip_select_n) |-> ##[1:8] s_loc_idle)
        else $error("Local acknowledge not released.");
    a_dtack_cause: assert property (
        $fell(dtack_n) |-> $past(iack_on, 2))
        else $error("Answer without acknowledge cycle.");
    a_answer_whole: assert property (
        !dtack_n || !vector_buffer_enable_n |-> s_answer)
        else $error("Answer signals disagree.");
    a_vector_addr: assert property (
        !vector_buffer_enable_n |-> vector_data_out[1:0] == level_addr[2:1])
        else $error("Vector low bits wrong.");
    a_pass_cause: assert property (
        $fell(iackout_n) |-> $past(iack_on, 2) && dtack_n)
        else $error("Chain passed without acknowledge cycle.");
    a_release_ds: assert property (
        $rose(ds0_n) |-> ##[1:8] s_sys_idle)
        else $error("System outputs not released.");
endmodule : vig_sva
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock;
    logic rst_n;
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic [15:0] r;
    int err_count;
    int checks;
    int cycles;

    vig_if u_vig_if ();
    vig_device u_vig_device (.clock(clock), .rst_n(rst_n), .bus(u_vig_if));
    vig_host u_vig_host (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .bus(u_vig_if)
    );
    vig_sva u_vig_sva (
        .clock(clock), .rst_n(rst_n),
        .level_addr(u_vig_if.level_addr),
        .qualified_chip_select_n(u_vig_if.qualified_chip_select_n),
        .local_transfer_ack_n(u_vig_if.local_transfer_ack_n),
        .dev_data_oe_n(u_vig_if.dev_data_oe_n),
        .iack_n(u_vig_if.iack_n), .iackin_n(u_vig_if.iackin_n),
        .ds0_n(u_vig_if.ds0_n), .iackout_n(u_vig_if.iackout_n),
        .dtack_n(u_vig_if.dtack_n),
        .vector_buffer_enable_n(u_vig_if.vector_buffer_enable_n),
        .vector_data_out(u_vig_if.vector_data_out),
        .irq_n(u_vig_if.irq_n)
    );

    // ----------
    // Bus tasks.
    // ----------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic wr_cmd(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
    endtask : wr_cmd

    task automatic rd_cmd(input logic [1:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'h1;
        @(posedge clock);
        rd <= 1'h0;
        #1;
        r = rdata;
    endtask : rd_cmd

    task automatic wait_idle;
        int i;
        for (i = 0; i < 200; i++) begin
            rd_cmd(2'h2);
            if (r[0] === 1'h0) break;
        end
        chk({15'h0000, r[0]}, 16'h0000);
    endtask : wait_idle

    task automatic loc(input logic rs, input logic rdn, input logic [6:0] d);
        wr_cmd(2'h0, {6'h00, rdn, rs, 1'h0, d});
        wait_idle();
        rd_cmd(2'h1);
    endtask : loc

    task automatic reg_is(input logic rs, input logic [6:0] e);
        loc(rs, 1'h1, 7'h00);
        chk({9'h000, r[6:0]}, {9'h000, e});
    endtask : reg_is

    task automatic pend_is(input logic [6:0] e);
        rd_cmd(2'h0);
        chk({9'h000, r[6:0]}, {9'h000, e});
    endtask : pend_is

    task automatic iak(input logic [2:0] l, input logic [1:0] e);
        wr_cmd(2'h2, {13'h0000, l});
        wait_idle();
        rd_cmd(2'h3);
        chk({14'h0000, r[2:1]}, {14'h0000, e});
    endtask : iak

    // ----------
    // Scenarios.
    // ----------
    task automatic t_reset;
        reg_is(vig_pkg::RS_VECTOR, 7'h00);
        reg_is(vig_pkg::RS_REQUEST, 7'h00);
        pend_is(7'h00);
    endtask : t_reset

    task automatic t_regs;
        loc(vig_pkg::RS_VECTOR, 1'h0, 7'h53);
        reg_is(vig_pkg::RS_VECTOR, 7'h51);
        loc(vig_pkg::RS_REQUEST, 1'h0, 7'h05);
        loc(vig_pkg::RS_REQUEST, 1'h0, 7'h40);
        reg_is(vig_pkg::RS_REQUEST, 7'h45);
        loc(vig_pkg::RS_REQUEST, 1'h0, 7'h00);
        reg_is(vig_pkg::RS_REQUEST, 7'h45);
        pend_is(7'h45);
        loc(vig_pkg::RS_VECTOR, 1'h0, 7'h53);
        reg_is(vig_pkg::RS_REQUEST, 7'h00);
        pend_is(7'h00);
        loc(vig_pkg::RS_REQUEST, 1'h0, 7'h01);
        reg_is(vig_pkg::RS_REQUEST, 7'h01);
        iak(3'h1, 2'h1);
        reg_is(vig_pkg::RS_REQUEST, 7'h00);
    endtask : t_regs

    task automatic t_enable;
        loc(vig_pkg::RS_VECTOR, 1'h0, 7'h50);
        loc(vig_pkg::RS_REQUEST, 1'h0, 7'h7F);
        reg_is(vig_pkg::RS_REQUEST, 7'h7F);
        pend_is(7'h00);
        iak(3'h2, 2'h2);
        reg_is(vig_pkg::RS_REQUEST, 7'h7F);
        loc(vig_pkg::RS_VECTOR, 1'h0, 7'h53);
        reg_is(vig_pkg::RS_REQUEST, 7'h00);
    endtask : t_enable

    task automatic t_ack_all;
        int l;
        logic [2:0] lv;
        for (l = 1; l <= 7; l++) begin
            lv = 3'(l);
            reg_is(vig_pkg::RS_REQUEST, 7'h00);
            loc(vig_pkg::RS_REQUEST, 1'h0, 7'h01 << (l - 1));
            pend_is(7'h01 << (l - 1));
            iak(lv, 2'h1);
            chk({9'h000, r[14:8]}, {9'h000, 5'h14, lv[2:1]});
            reg_is(vig_pkg::RS_REQUEST, 7'h00);
            pend_is(7'h00);
            iak(lv, 2'h2);
        end
        iak(3'h0, 2'h2);
    endtask : t_ack_all

    // ----------
    // Control.
    // ----------
    task automatic report_and_stop;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        rst_n = 1'h0;
        addr = 2'h0;
        wdata = 16'h0000;
        wr = 1'h0;
        rd = 1'h0;
        err_count = 0;
        checks = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        t_reset();
        t_regs();
        t_enable();
        t_ack_all();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
